/* File: tpg_top.sv */
// Test pattern generator and per-channel digital gain with AXI4-Lite registers
//
// Notes on behaviour
// RULE1 - Pattern clock select bit 4: 0 sampling strobe, 1 decimation strobe.
// RULE2 - Pattern type 000 turns the generator off; this is the reset value.
// RULE3 - The generator makes one 20-bit word per pattern clock; the code skips a pattern clock that finds the FIFO full.
// RULE4 - In 16-bit resolution only the upper 16 pattern bits are sent.
// RULE5 - In 32-bit resolution the pattern is padded with 12 zero bits.
// RULE6 - Type 001 is a ramp stepping by one at 20-bit level.
// RULE7 - Type 010 is a ramp stepping by the user pattern value.
// RULE8 - Type 100 sends the user pattern value unchanged.
// RULE9 - Type 101 alternates user value and its bitwise inverse.
// RULE10 - Type 110 alternates user value and all zeros.
// RULE11 - User value is three byte registers; top register keeps only its low nibble.
// RULE12 - User value means step, static value or toggle operand by type.
// RULE13 - Channel A is scaled by 1 + G/128, G signed 8-bit.
// RULE14 - Channel B is scaled by 1 + G/128 with its own gain.
// RULE15 - Unused types 011 and 111 behave as pattern off.
// RULE16 - An active pattern replaces converter samples on the output.
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
module tpg_top
  import tpg_pkg::*;
#(
  parameter int FIFO_DEPTH = TPG_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // AXI4-Lite write address
  input  wire logic [TPG_AXI_AW-1:0] s_axi_awaddr,
  input  wire logic [2:0]            s_axi_awprot,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  // AXI4-Lite write data and response
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // AXI4-Lite read
  input  wire logic [TPG_AXI_AW-1:0] s_axi_araddr,
  input  wire logic [2:0]            s_axi_arprot,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // Converter side, same clock domain
  input  wire logic                  samp_stb,
  input  wire logic                  dec_stb,
  input  wire logic                  sample_valid,
  output logic                       sample_ready,
  input  wire logic [TPG_SMP_W-1:0]  chan_a_sample,
  input  wire logic [TPG_SMP_W-1:0]  chan_b_sample,
  // Output stream to the serializer
  output logic                       out_valid,
  input  wire logic                  out_ready,
  output logic [TPG_WORD_W-1:0]      out_data_a,
  output logic [TPG_WORD_W-1:0]      out_data_b
);

  localparam int DW = 2 * TPG_WORD_W;

  // Register state
  logic [2:0]           pat_type_q;
  logic                 pat_clk_sel_q;
  logic [7:0]           user_lo_q;
  logic [7:0]           user_mid_q;
  logic [3:0]           user_hi_q;
  logic [7:0]           channel_a_gain_q;
  logic [7:0]           channel_b_gain_q;
  logic                 out_res_q;

  // Bus state
  logic                 aw_have_q;
  logic                 w_have_q;
  logic [8:0]           aw_idx_q;
  logic [31:0]          wdata_q;
  logic                 wstrb0_q;

  // Pattern state
  logic [TPG_PAT_W-1:0] ramp_q;
  logic                 phase_q;
  logic [TPG_PAT_W-1:0] user_pattern_value;
  logic [TPG_PAT_W-1:0] pat_word;
  logic                 pat_active;
  logic                 pat_tick;

  // Datapath
  logic [TPG_SMP_W-1:0] gained [2];
  logic [TPG_WORD_W-1:0] chan_word [2];
  logic [TPG_WORD_W-1:0] pat_out;
  logic                 fifo_push;
  logic                 fifo_take;
  logic                 out_valid_q;
  logic [DW-1:0]        out_data_q;

  tpg_stream_if #(.W(DW)) fifo_in ();
  tpg_stream_if #(.W(DW)) fifo_out ();

  // User value from three byte registers
  assign user_pattern_value = {user_hi_q, user_mid_q, user_lo_q}; // RULE11

  // Only documented codes run the generator; 011 and 111 pass samples
  always_comb
  begin
    unique case (tpg_pat_e'(pat_type_q))
      TPG_PAT_RAMP1, TPG_PAT_RAMPU, TPG_PAT_STATIC, TPG_PAT_TOGINV, TPG_PAT_TOGZ:
        pat_active = 1'b1;
      TPG_PAT_OFF, TPG_PAT_UNU3, TPG_PAT_UNU7:
        pat_active = 1'b0; // RULE2 RULE15
    endcase
  end

  // Pattern clock choice; a full FIFO holds the pattern rather than drop words
  assign pat_tick = (pat_clk_sel_q ? dec_stb : samp_stb) & pat_active & fifo_in.ready; // RULE1

  // Word for this pattern clock; meaning of the user value follows the type
  always_comb
  begin
    unique case (tpg_pat_e'(pat_type_q))
      TPG_PAT_RAMP1,
      TPG_PAT_RAMPU:  pat_word = ramp_q; // RULE6 RULE7
      TPG_PAT_STATIC: pat_word = user_pattern_value; // RULE8 RULE12
      TPG_PAT_TOGINV: pat_word = phase_q ? ~user_pattern_value : user_pattern_value; // RULE9
      TPG_PAT_TOGZ:   pat_word = phase_q ? '0 : user_pattern_value; // RULE10
      TPG_PAT_OFF, TPG_PAT_UNU3, TPG_PAT_UNU7:
                      pat_word = '0;
    endcase
  end

  // Ramp and toggle phase advance once per pattern clock
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !pat_active)
    begin
      ramp_q  <= '0;
      phase_q <= 1'b0;
    end
    else if (pat_tick)
    begin
      phase_q <= ~phase_q;
      if (pat_type_q == TPG_PAT_RAMP1)
        ramp_q <= ramp_q + TPG_PAT_W'(1); // RULE6 RULE3
      else if (pat_type_q == TPG_PAT_RAMPU)
        ramp_q <= ramp_q + user_pattern_value; // RULE7 RULE12
    end
  end

  // Resolution fit: 16-bit keeps the top bits, 32-bit pads low zeros
  assign pat_out = out_res_q ? {pat_word, 12'h000} // RULE5
                             : {16'h0000, pat_word[TPG_PAT_W-1 -: TPG_SMP_W]}; // RULE4

  // Per-channel gain: sample * (128 + G) / 128, saturated to 16 bits
  generate
    for (genvar c = 0; c < 2; c++)
    begin : g_chan
      logic [7:0]            gain;
      logic [8:0]            mult;
      logic signed [24:0]    prod;
      logic signed [17:0]    scaled;
      assign gain   = (c == 0) ? channel_a_gain_q : channel_b_gain_q;
      assign mult   = TPG_GAIN_UNITY + {gain[7], gain}; // RULE13 RULE14
      assign prod   = $signed((c == 0) ? chan_a_sample : chan_b_sample)
                      * $signed({1'b0, mult[7:0]});
      assign scaled = prod[24:TPG_GAIN_SHIFT];
      // Positive G up to 127 can exceed full scale, so clip rather than wrap
      assign gained[c] = (scaled[17:15] == 3'h0 || scaled[17:15] == 3'h7) ? scaled[15:0]
                       : (scaled[17] ? 16'h8000 : 16'h7FFF);
      assign chan_word[c] = out_res_q ? {gained[c], 16'h0000} : {16'h0000, gained[c]};
    end
  endgenerate

  // Pattern replaces samples; samples offered meanwhile are taken and discarded
  assign fifo_push     = pat_active ? pat_tick : sample_valid; // RULE16
  assign fifo_in.valid = fifo_push;
  assign fifo_in.data  = pat_active ? {pat_out, pat_out} : {chan_word[1], chan_word[0]}; // RULE16
  assign sample_ready  = fifo_in.ready;

  tpg_fifo #(
    .WIDTH (DW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .aclk    (aclk),
    .aresetn (aresetn),
    .in_s    (fifo_in),
    .out_s   (fifo_out)
  );

  // Output register keeps the outputs on flops and passes back-pressure
  assign fifo_take      = fifo_out.valid && (!out_valid_q || out_ready);
  assign fifo_out.ready = !out_valid_q || out_ready;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      out_valid_q <= 1'b0;
      out_data_q  <= '0;
    end
    else if (!out_valid_q || out_ready)
    begin
      out_valid_q <= fifo_out.valid;
      if (fifo_take)
        out_data_q <= fifo_out.data;
    end
  end

  assign out_valid  = out_valid_q;
  assign out_data_a = out_data_q[TPG_WORD_W-1:0];
  assign out_data_b = out_data_q[DW-1:TPG_WORD_W];

  // Write address and data are caught independently, in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      aw_idx_q      <= '0;
      wdata_q       <= '0;
      wstrb0_q      <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= TPG_RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= !aw_have_q && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready  <= !w_have_q && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_q <= 1'b1;
        aw_idx_q  <= s_axi_awaddr[TPG_AXI_AW-2:2];
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb0_q <= s_axi_wstrb[0];
      end
      if (aw_have_q && w_have_q)
      begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= idx_mapped(aw_idx_q) ? TPG_RESP_OKAY : TPG_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Register writes; only byte lane 0 carries the 8-bit fields
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pat_type_q       <= TPG_PAT_TYPE_RST; // RULE2
      pat_clk_sel_q    <= TPG_PAT_CLK_RST;
      user_lo_q        <= TPG_BYTE_RST;
      user_mid_q       <= TPG_BYTE_RST;
      user_hi_q        <= TPG_BYTE_RST[3:0];
      channel_a_gain_q <= TPG_BYTE_RST;
      channel_b_gain_q <= TPG_BYTE_RST;
      out_res_q        <= TPG_OUT_RES_RST;
    end
    else if (aw_have_q && w_have_q && wstrb0_q)
    begin
      unique case (aw_idx_q)
        TPG_IDX_PAT_CTRL:
        begin
          pat_type_q    <= wdata_q[2:0];
          pat_clk_sel_q <= wdata_q[TPG_PAT_CLK_BIT]; // RULE1
        end
        TPG_IDX_USER_LO:  user_lo_q        <= wdata_q[7:0]; // RULE11
        TPG_IDX_USER_MID: user_mid_q       <= wdata_q[7:0]; // RULE11
        TPG_IDX_USER_HI:  user_hi_q        <= wdata_q[3:0]; // RULE11
        TPG_IDX_GAIN_A:   channel_a_gain_q <= wdata_q[7:0]; // RULE13
        TPG_IDX_GAIN_B:   channel_b_gain_q <= wdata_q[7:0]; // RULE14
        TPG_IDX_OUT_CFG:  out_res_q        <= wdata_q[TPG_OUT_RES_BIT];
        default:          ;
      endcase
    end
  end

  // Decode of mapped indices, shared by read and write
  function automatic logic idx_mapped(input logic [8:0] idx);
    idx_mapped = (idx == TPG_IDX_PAT_CTRL) || (idx == TPG_IDX_USER_LO) ||
                 (idx == TPG_IDX_USER_MID) || (idx == TPG_IDX_USER_HI) ||
                 (idx == TPG_IDX_GAIN_A)   || (idx == TPG_IDX_GAIN_B)  ||
                 (idx == TPG_IDX_OUT_CFG)  || (idx == TPG_IDX_STATUS);
  endfunction

  // Read channel: one read in flight; reserved bits read zero
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= TPG_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= idx_mapped(s_axi_araddr[TPG_AXI_AW-2:2]) ? TPG_RESP_OKAY : TPG_RESP_SLVERR;
        unique case (s_axi_araddr[TPG_AXI_AW-2:2])
          TPG_IDX_PAT_CTRL: s_axi_rdata <= {27'h0, pat_clk_sel_q, 1'b0, pat_type_q};
          TPG_IDX_USER_LO:  s_axi_rdata <= {24'h0, user_lo_q};
          TPG_IDX_USER_MID: s_axi_rdata <= {24'h0, user_mid_q};
          TPG_IDX_USER_HI:  s_axi_rdata <= {28'h0, user_hi_q}; // RULE11
          TPG_IDX_GAIN_A:   s_axi_rdata <= {24'h0, channel_a_gain_q};
          TPG_IDX_GAIN_B:   s_axi_rdata <= {24'h0, channel_b_gain_q};
          TPG_IDX_OUT_CFG:  s_axi_rdata <= {30'h0, out_res_q, 1'b0};
          TPG_IDX_STATUS:   s_axi_rdata <= {8'h0, 4'h0, ramp_q[19:16], 7'h0, phase_q,
                                            5'h0, fifo_out.valid, fifo_in.ready, pat_active};
          default:          s_axi_rdata <= '0;
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule

/* File: tpg_pkg.sv */
// Shared constants and types for the test pattern and digital gain block
package tpg_pkg;

  // Register indices as printed; byte address is four times the index
  localparam logic [8:0]  TPG_IDX_PAT_CTRL  = 9'h14A;
  localparam logic [8:0]  TPG_IDX_USER_LO   = 9'h14B;
  localparam logic [8:0]  TPG_IDX_USER_MID  = 9'h14C;
  localparam logic [8:0]  TPG_IDX_USER_HI   = 9'h14D;
  localparam logic [8:0]  TPG_IDX_GAIN_A    = 9'h15B;
  localparam logic [8:0]  TPG_IDX_GAIN_B    = 9'h15C;
  localparam logic [8:0]  TPG_IDX_OUT_CFG   = 9'h162;
  localparam logic [8:0]  TPG_IDX_STATUS    = 9'h17F;

  // AXI4-Lite geometry
  localparam int          TPG_AXI_AW        = 12;
  localparam logic [1:0]  TPG_RESP_OKAY     = 2'h0;
  localparam logic [1:0]  TPG_RESP_SLVERR   = 2'h2;

  // Field positions
  localparam int          TPG_PAT_CLK_BIT   = 4;
  localparam int          TPG_OUT_RES_BIT   = 1;

  // Reset values
  localparam logic [2:0]  TPG_PAT_TYPE_RST  = 3'h0;
  localparam logic        TPG_PAT_CLK_RST   = 1'h0;
  localparam logic [7:0]  TPG_BYTE_RST      = 8'h00;
  localparam logic        TPG_OUT_RES_RST   = 1'h0;

  // Pattern and gain arithmetic
  localparam int          TPG_PAT_W         = 20;
  localparam int          TPG_SMP_W         = 16;
  localparam int          TPG_WORD_W        = 32;
  localparam int          TPG_GAIN_SHIFT    = 7;
  localparam logic [8:0]  TPG_GAIN_UNITY    = 9'h080;
  localparam int          TPG_FIFO_DEPTH    = 16;

  // Pattern type codes
  typedef enum logic [2:0] {
    TPG_PAT_OFF    = 3'h0,
    TPG_PAT_RAMP1  = 3'h1,
    TPG_PAT_RAMPU  = 3'h2,
    TPG_PAT_UNU3   = 3'h3,
    TPG_PAT_STATIC = 3'h4,
    TPG_PAT_TOGINV = 3'h5,
    TPG_PAT_TOGZ   = 3'h6,
    TPG_PAT_UNU7   = 3'h7
  } tpg_pat_e;

endpackage

/* File: tpg_stream_if.sv */
// Valid/ready stream carrier between the block and its FIFO
`timescale 1ns/1ps
interface tpg_stream_if #(parameter int W = 64);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

/* File: tpg_fifo.sv */
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module tpg_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Filling side
  tpg_stream_if.snk in_s,
  // Draining side
  tpg_stream_if.src out_s
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wptr_q;
  logic [AW-1:0]    rptr_q;
  logic [CW-1:0]    count_q;
  logic [CW-1:0]    count_d;
  logic             ready_q;
  logic             push;
  logic             pop;

  // Handshakes on each side
  assign push        = in_s.valid & ready_q;
  assign pop         = out_s.valid & out_s.ready;
  assign in_s.ready  = ready_q;
  assign out_s.valid = (count_q != '0);
  assign out_s.data  = mem[rptr_q];

  // Occupancy after this edge
  always_comb
  begin
    count_d = count_q;
    if (push && !pop)
      count_d = count_q + CW'(1);
    else if (pop && !push)
      count_d = count_q - CW'(1);
  end

  // Storage has no reset; only pointers, count and ready need a defined state
  always_ff @(posedge aclk)
  begin
    if (push)
      mem[wptr_q] <= in_s.data;
  end

  // Pointers, count and registered ready
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wptr_q  <= '0;
      rptr_q  <= '0;
      count_q <= '0;
      ready_q <= 1'b0;
    end
    else
    begin
      if (push)
        wptr_q <= (wptr_q == AW'(DEPTH - 1)) ? '0 : wptr_q + AW'(1);
      if (pop)
        rptr_q <= (rptr_q == AW'(DEPTH - 1)) ? '0 : rptr_q + AW'(1);
      count_q <= count_d;
      ready_q <= (count_d != CW'(DEPTH));
    end
  end

endmodule

/* File: tpg_sink_model.sv */
// Behavioural output serializer that records every word it takes
`timescale 1ns/1ps
module tpg_sink_model (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Stream from the block
  input  wire logic        in_valid,
  output logic             in_ready,
  input  wire logic [31:0] in_data_a,
  input  wire logic [31:0] in_data_b,
  // Pacing from the bench
  input  wire logic        stall,
  input  wire logic        slow
);
  logic [31:0] qa[$];
  logic [31:0] qb[$];

  // Slow mode toggles ready so the block must hold its word across stalls
  always @(posedge aclk)
  begin
    in_ready <= aresetn && !stall && !(slow && in_ready);
    if (in_valid === 1'b1 && in_ready === 1'b1)
    begin
      qa.push_back(in_data_a);
      qb.push_back(in_data_b);
    end
  end
endmodule

/* File: tpg_top_asserts.sv */
// Port-level checker for the pattern and gain block
`timescale 1ns/1ps
module tpg_top_asserts
  import tpg_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Register bus
  input  wire logic        s_axi_awvalid,
  input  wire logic        s_axi_awready,
  input  wire logic        s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  // Output stream
  input  wire logic        out_valid,
  input  wire logic        out_ready,
  input  wire logic [31:0] out_data_a,
  input  wire logic [31:0] out_data_b
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // A stalled word must not change under the serializer
  AST_OUT_HOLD: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data_a) && $stable(out_data_b))
    else $error("output word changed while stalled");
  // Either the 16-bit or the 32-bit packing leaves a zero field
  AST_PACK_A: assert property (out_valid |-> out_data_a[31:16] == 16'h0000 || out_data_a[11:0] == 12'h000)
    else $error("channel A word packing wrong");
  AST_PACK_B: assert property (out_valid |-> out_data_b[31:16] == 16'h0000 || out_data_b[11:0] == 12'h000)
    else $error("channel B word packing wrong");
  AST_B_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  AST_AW_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("new write accepted before response done");
  AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed while pending");
  AST_SLV_ZERO: assert property (s_axi_rvalid && s_axi_rresp == TPG_RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("refused read returned data");
endmodule

bind tpg_top tpg_top_asserts chk_u (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata, .s_axi_rresp, .out_valid, .out_ready, .out_data_a, .out_data_b);

/* File: test_pattern_and_digital_gain_tb_top.sv */
// Self-checking bench for the pattern generator and gain block
`timescale 1ns/1ps
module test_pattern_and_digital_gain_tb_top;
  import tpg_pkg::*;
  localparam logic [19:0] UV = 20'h93C5A;
  logic        aclk = 1'b0, aresetn = 1'b0, stall = 1'b0, slow = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, out_data_a, out_data_b, rd;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0, samp_stb = 1'b0, dec_stb = 1'b0, sample_valid = 1'b0;
  logic [15:0] chan_a_sample = 16'h0, chan_b_sample = 16'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        sample_ready, out_valid, out_ready, ok;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
  int          err_total = 0;
  int          n_tests = 0;

  always #50 aclk = ~aclk;

  tpg_top #(.FIFO_DEPTH(16)) dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .samp_stb, .dec_stb, .sample_valid, .sample_ready, .chan_a_sample, .chan_b_sample,
    .out_valid, .out_ready, .out_data_a, .out_data_b);
  tpg_sink_model sink_u (.aclk, .aresetn, .in_valid(out_valid), .in_ready(out_ready), .in_data_a(out_data_a),
    .in_data_b(out_data_b), .stall, .slow);

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // A used-up wait bound is a mismatch and ends the run
  task automatic tmo();
    err_total++;
    $display("wait limit reached t=%0t", $time);
    test_done();
  endtask

  // Write one register; address and data offered together, bready held until bvalid
  task automatic axw(input logic [8:0] idx, input logic [31:0] d, input logic [1:0] er);
    bit aw, w;
    int n;
    aw = 1;
    w = 1;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= {1'b0, idx, 2'b00};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (++n > 60) tmo();
      if (aw && s_axi_awready === 1'b1) begin aw = 0; s_axi_awvalid <= 1'b0; end
      if (w && s_axi_wready === 1'b1) begin w = 0; s_axi_wvalid <= 1'b0; end
      if (!aw && !w && s_axi_bvalid === 1'b1) break;
    end
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(er));
  endtask

  task automatic axr(input logic [8:0] idx, output logic [31:0] d, output logic [1:0] r);
    bit ar;
    int n;
    ar = 1;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= {1'b0, idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (++n > 60) tmo();
      if (ar && s_axi_arready === 1'b1) begin ar = 0; s_axi_arvalid <= 1'b0; end
      if (!ar && s_axi_rvalid === 1'b1) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic smp(input logic [15:0] a, input logic [15:0] b, input int bound, output logic k);
    k = 1'b0;
    @(posedge aclk);
    sample_valid <= 1'b1;
    chan_a_sample <= a;
    chan_b_sample <= b;
    for (int n = 0; n < bound && !k; n++)
    begin
      @(posedge aclk);
      k = (sample_ready === 1'b1);
    end
    sample_valid <= 1'b0;
  endtask

  // Unselected strobe pulses before each tick and once after the last
  task automatic ticks(input logic sel, input int n);
    repeat (n)
    begin
      @(posedge aclk);
      samp_stb <= sel;
      dec_stb <= !sel;
      @(posedge aclk);
      samp_stb <= !sel;
      dec_stb <= sel;
    end
    @(posedge aclk);
    samp_stb <= sel;
    dec_stb <= !sel;
    @(posedge aclk);
    samp_stb <= 1'b0;
    dec_stb <= 1'b0;
  endtask

  // Waiting on past the count catches surplus words
  task automatic drain(input int n);
    int i;
    for (i = 0; i < 300 && sink_u.qa.size() < n; i++) @(posedge aclk);
    if (i == 300) tmo();
    repeat (8) @(posedge aclk);
    chk(32'(sink_u.qa.size()), 32'(n));
  endtask

  task automatic clr();
    sink_u.qa.delete();
    sink_u.qb.delete();
  endtask

  function automatic logic [31:0] pw(input logic [2:0] t, input int k, input logic r32);
    logic [19:0] p;
    case (t)
      3'h1: p = 20'(k);
      3'h2: p = 20'(UV * k);
      3'h4: p = UV;
      3'h5: p = k[0] ? ~UV : UV;
      3'h6: p = k[0] ? 20'h00000 : UV;
      default: p = 20'h00000;
    endcase
    return r32 ? {p, 12'h000} : {16'h0000, p[19:4]};
  endfunction

  task automatic t_regs();
    logic [8:0] ix[7] = '{TPG_IDX_PAT_CTRL, TPG_IDX_USER_LO, TPG_IDX_USER_MID, TPG_IDX_USER_HI,
                          TPG_IDX_GAIN_A, TPG_IDX_GAIN_B, TPG_IDX_OUT_CFG};
    foreach (ix[i])
    begin
      axr(ix[i], rd, rr);
      chk(rd, 32'h0);
    end
    axw(TPG_IDX_PAT_CTRL, 32'hFF, TPG_RESP_OKAY);
    axr(TPG_IDX_PAT_CTRL, rd, rr);
    chk(rd, 32'h17);
    axw(TPG_IDX_USER_HI, 32'hFF, TPG_RESP_OKAY);
    axr(TPG_IDX_USER_HI, rd, rr);
    chk(rd, 32'h0F);
    axw(9'h150, 32'h1, TPG_RESP_SLVERR);
    axr(9'h150, rd, rr);
    chk({rd[29:0], rr}, {30'h0, TPG_RESP_SLVERR});
    axw(TPG_IDX_PAT_CTRL, 32'h0, TPG_RESP_OKAY);
    $display("test regs ended");
  endtask

  task automatic t_gain();
    logic [31:0] t7[2] = '{32'h3, 32'h7};
    clr();
    axw(TPG_IDX_GAIN_A, 32'h7F, TPG_RESP_OKAY);
    axw(TPG_IDX_GAIN_B, 32'hC0, TPG_RESP_OKAY);
    smp(16'h1000, 16'hE000, 40, ok);
    smp(16'h7000, 16'h0081, 40, ok);
    axw(TPG_IDX_OUT_CFG, 32'h2, TPG_RESP_OKAY);
    smp(16'h1000, 16'h0081, 40, ok);
    drain(3);
    chk(sink_u.qa[0], 32'h00001FE0);
    chk(sink_u.qa[1], 32'h00007FFF);
    chk(sink_u.qa[2], 32'h1FE00000);
    chk(sink_u.qb[0], 32'h0000F000);
    chk(sink_u.qb[1], 32'h00000040);
    chk(sink_u.qb[2], 32'h00400000);
    axw(TPG_IDX_OUT_CFG, 32'h0, TPG_RESP_OKAY);
    foreach (t7[i])
    begin
      clr();
      axw(TPG_IDX_PAT_CTRL, t7[i], TPG_RESP_OKAY);
      ticks(1'b0, 2);
      smp(16'h1000, 16'hE000, 40, ok);
      drain(1);
      chk(sink_u.qa[0], 32'h00001FE0);
      chk(sink_u.qb[0], 32'h0000F000);
    end
    axw(TPG_IDX_PAT_CTRL, 32'h0, TPG_RESP_OKAY);
    $display("test gain ended");
  endtask

  task automatic t_pat();
    logic [2:0] ty[6] = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h5};
    logic r32;
    axw(TPG_IDX_USER_LO, 32'h5A, TPG_RESP_OKAY);
    axw(TPG_IDX_USER_MID, 32'h3C, TPG_RESP_OKAY);
    axw(TPG_IDX_USER_HI, 32'h09, TPG_RESP_OKAY);
    slow <= 1'b1;
    foreach (ty[i])
    begin
      r32 = (i % 5 == 0);
      clr();
      axw(TPG_IDX_OUT_CFG, {30'h0, r32, 1'b0}, TPG_RESP_OKAY);
      axw(TPG_IDX_PAT_CTRL, {27'h0, i[0], 1'b0, ty[i]}, TPG_RESP_OKAY);
      ticks(i[0], 4);
      smp(16'h1234, 16'h4321, 40, ok);
      drain(4);
      for (int k = 0; k < 4; k++)
      begin
        chk(sink_u.qa[k], pw(ty[i], k, r32));
        chk(sink_u.qb[k], pw(ty[i], k, r32));
      end
      axw(TPG_IDX_PAT_CTRL, 32'h0, TPG_RESP_OKAY);
    end
    axw(TPG_IDX_OUT_CFG, 32'h0, TPG_RESP_OKAY);
    slow <= 1'b0;
    $display("test pattern ended");
  endtask

  // Fill the buffer against a stalled serializer, then drain it in order
  task automatic t_fill();
    int acc;
    acc = 0;
    clr();
    axw(TPG_IDX_GAIN_A, 32'h0, TPG_RESP_OKAY);
    axw(TPG_IDX_GAIN_B, 32'h0, TPG_RESP_OKAY);
    stall <= 1'b1;
    do
    begin
      smp(16'h0100 + 16'(acc), 16'h0200 + 16'(acc), 12, ok);
      acc += ok;
    end
    while (ok && acc < 24);
    chk(32'(sample_ready), 32'h0);
    chk(32'(acc >= 16 && acc <= 18), 32'h1);
    stall <= 1'b0;
    drain(acc);
    for (int k = 0; k < acc; k++)
    begin
      chk(sink_u.qa[k], 32'h00000100 + 32'(k));
      chk(sink_u.qb[k], 32'h00000200 + 32'(k));
    end
    $display("test fill ended");
  endtask

  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_regs();
    t_gain();
    t_pat();
    t_fill();
    test_done();
  end
endmodule
